/* File: include/idp_pkg.sv */
/*
 Constants, types and state layouts for the interrupt distribution block.
 Assumes one 100 MHz clock and an active-low asynchronous reset.
*/
// Overview of operation
// - Processor interface count is a build parameter from one to eight.
// - Up to sixteen software interrupts per processor, identifiers 0 to 15.
// - Zero to sixteen private interrupts per processor when several processors exist.
// - Private lines of processor n reach processor n only.
// - Up to 988 shared interrupts carry identifiers 32 to 1019.
// - Shared inputs go to the processors chosen by their target bits.
// - Up to two legacy inputs per processor; fast one only with security.
// - Private trigger mode fixed at build time; configuration writes cannot change it.
// - Lockable shared count is a build option, reported in type field.
// - Number of priority levels is a build parameter.
// - Priority changes apply at once to active shared interrupts only.
// - Equal-priority private or shared ties go to lowest identifier.
// - Software ties go to lowest identifier, then lowest source processor.
// - Active-and-pending interrupts are excluded from selection.
// - Multi-target shared interrupts signal all targets together; first acknowledger wins.
// - Later acknowledgers of that interrupt get a spurious answer.
// - Security bits all clear at reset.
// - Secure access reaches all interface registers; non-secure only permitted ones.
// - Least binary point value follows from the priority level count.
// - Pulse recognised when input seen low then high on successive edges.
// - Synchronised inputs add two clock cycles of latency.
// - Banked access selected only when masked identifier equals compare bits.
// - Interface accepts only priority above mask and running priority.
package idp_pkg;
    localparam int ID_W = 10;
    localparam int PRIO_W = 8;
    localparam logic [ID_W-1:0] SPURIOUS_ID = 10'h3FF;
    localparam logic [ID_W-1:0] PPI_BASE = 10'h010;
    localparam logic [ID_W-1:0] SPI_BASE = 10'h020;
    localparam int SGI_MAX = 16;
    localparam int PPI_MAX = 16;
    localparam int SPI_MAX = 988;
    localparam int CPU_MAX = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [PRIO_W-1:0] PRIO_IDLE = 8'hFF;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 8'h00;
    typedef enum logic [2:0] {
        IDP_IDLE = 3'b001,
        IDP_SIGNAL = 3'b010,
        IDP_ACTIVE = 3'b100
    } idp_state_e;
endpackage : idp_pkg

/* File: rtl/idp_in_cond.sv */
/*
 Input conditioning for one interrupt line: optional two-stage synchroniser,
 optional rising-edge detection for pulse-sensitive inputs.
 Assumes the raw line may be asynchronous to clock.
*/
`timescale 1ns/1ps
module idp_in_cond #(
    parameter bit SYNC = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // Line
    input wire logic raw,
    input wire logic pulse_mode,
    output logic level,
    output logic edge_seen
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } idp_cond_s;
    idp_cond_s st_r;
    idp_cond_s st_nxt;
    logic seen;
    assign seen = SYNC ? st_r.s2 : raw;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = seen;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end
    assign level = seen;
    assign edge_seen = pulse_mode & seen & ~st_r.prev;
endmodule : idp_in_cond

/* File: rtl/idp_distributor.sv */
/*
 Interrupt distributor with per-processor interfaces. Software, private and
 shared interrupts, pending/active state, priority arbitration, acknowledge and
 end-of-interrupt per processor. Configuration arrives on plain ports.
 Assumes processors pulse ack/eoi; configuration is held steady by software logic.
*/
`timescale 1ns/1ps
module idp_distributor #(
    parameter int NCPU = 2,
    parameter int NPPI = 16,
    parameter int NSPI = 32,
    parameter int NLOCK = 0,
    parameter int PRIO_BITS = 4,
    parameter bit SEC_EXT = 1'b1,
    parameter logic [15:0] PPI_PULSE = 16'h0000,
    parameter bit SYNC_IN = 1'b1,
    parameter int ID_TAG_W = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    // Interrupt inputs
    input wire logic [NCPU*NPPI-1:0] ppi_in,
    input wire logic [NSPI-1:0] spi_in,
    input wire logic [NCPU-1:0] legacy_irq_n,
    input wire logic [NCPU-1:0] legacy_fiq_n,
    // Software interrupt request
    input wire logic sgi_req,
    input wire logic [3:0] sgi_id,
    input wire logic [NCPU-1:0] sgi_targets,
    input wire logic [2:0] sgi_source,
    // Configuration
    input wire logic dist_enable,
    input wire logic [NSPI-1:0] spi_pulse_mode,
    input wire logic [NSPI*NCPU-1:0] spi_targets,
    input wire logic [NSPI*idp_pkg::PRIO_W-1:0] spi_prio,
    input wire logic [NSPI-1:0] spi_group1,
    input wire logic [NCPU*idp_pkg::PRIO_W-1:0] ppi_prio,
    input wire logic [NCPU*idp_pkg::PRIO_W-1:0] sgi_prio,
    input wire logic [NCPU*idp_pkg::PRIO_W-1:0] prio_mask,
    input wire logic [NCPU-1:0] cpu_enable,
    input wire logic [NCPU-1:0] legacy_bypass,
    // Bank selection and build-time values
    input wire logic [ID_TAG_W-1:0] bus_id,
    input wire logic bus_secure,
    input wire logic [NCPU*ID_TAG_W-1:0] id_mask,
    input wire logic [NCPU*ID_TAG_W-1:0] id_match,
    input wire logic [3:0] bin_point_req,
    output logic [NCPU-1:0] bank_sel,
    output logic [NCPU-1:0] bank_ns_ok,
    output logic [3:0] min_bin_point,
    output logic [4:0] lockable_count,
    // Processor handshake
    input wire logic [NCPU-1:0] ack,
    input wire logic [NCPU-1:0] eoi,
    output logic [NCPU*idp_pkg::ID_W-1:0] ack_id,
    output logic [NCPU*3-1:0] ack_src,
    output logic [NCPU-1:0] nirq,
    output logic [NCPU-1:0] nfiq,
    output logic [NSPI-1:0] spi_active,
    output logic [NSPI-1:0] spi_security
);
    localparam int W = idp_pkg::PRIO_W;
    localparam int IW = idp_pkg::ID_W;
    typedef struct packed {
        logic [NSPI-1:0] spi_pend;
        logic [NSPI-1:0] spi_act;
        logic [NSPI-1:0] spi_sec;
        logic [NCPU*NPPI-1:0] ppi_pend;
        logic [NCPU*NPPI-1:0] ppi_act;
        logic [NCPU*16*8-1:0] sgi_pend;
        logic [NCPU*16-1:0] sgi_act;
        logic [NCPU*IW-1:0] run_id;
        logic [NCPU*W-1:0] run_prio;
        logic [NCPU*IW-1:0] ack_id;
        logic [NCPU*3-1:0] ack_src;
        logic [NCPU-1:0] nirq;
        logic [NCPU-1:0] nfiq;
    } idp_dist_s;
    idp_dist_s st_r;
    idp_dist_s st_nxt;
    logic [NSPI-1:0] spi_lvl;
    logic [NSPI-1:0] spi_edge;
    logic [NCPU*NPPI-1:0] ppi_lvl;
    logic [NCPU*NPPI-1:0] ppi_edge;
    logic [NCPU-1:0] leg_irq;
    logic [NCPU-1:0] leg_fiq;
    logic [W-1:0] prio_lsb_mask;
    genvar g;
    generate
        for (g = 0; g < NSPI; g++) begin : g_spi
            idp_in_cond #(.SYNC(SYNC_IN)) u_cond (
                .clock(clock), .rstn(rstn), .clk_en(clk_en), .raw(spi_in[g]),
                .pulse_mode(spi_pulse_mode[g]), .level(spi_lvl[g]), .edge_seen(spi_edge[g]));
        end
        for (g = 0; g < NCPU*NPPI; g++) begin : g_ppi
            idp_in_cond #(.SYNC(SYNC_IN)) u_cond (
                .clock(clock), .rstn(rstn), .clk_en(clk_en), .raw(ppi_in[g]),
                .pulse_mode(PPI_PULSE[g % NPPI]), .level(ppi_lvl[g]), .edge_seen(ppi_edge[g]));
        end
        for (g = 0; g < NCPU; g++) begin : g_leg
            idp_in_cond #(.SYNC(SYNC_IN)) u_irq (
                .clock(clock), .rstn(rstn), .clk_en(clk_en), .raw(~legacy_irq_n[g]),
                .pulse_mode(1'b0), .level(leg_irq[g]), .edge_seen());
            idp_in_cond #(.SYNC(SYNC_IN)) u_fiq (
                .clock(clock), .rstn(rstn), .clk_en(clk_en), .raw(~legacy_fiq_n[g] & SEC_EXT),
                .pulse_mode(1'b0), .level(leg_fiq[g]), .edge_seen());
        end
    endgenerate
    assign min_bin_point = 4'(idp_pkg::PRIO_W - PRIO_BITS - 1);
    assign prio_lsb_mask = W'({W{1'b1}} << (W - PRIO_BITS));
    assign lockable_count = 5'(NLOCK);
    always_comb begin
        for (int c = 0; c < NCPU; c++) begin
            bank_sel[c] = (bus_id & id_mask[c*ID_TAG_W +: ID_TAG_W]) == id_match[c*ID_TAG_W +: ID_TAG_W];
            bank_ns_ok[c] = bank_sel[c] & ~bus_secure;
        end
    end
    always_comb begin
        logic [W-1:0] best_p;
        logic [IW-1:0] best_id;
        logic [2:0] best_src;
        logic best_v;
        logic best_g1;
        logic [W-1:0] p;
        logic won;
        st_nxt = st_r;
        best_p = '0;
        best_id = '0;
        best_src = '0;
        best_v = 1'b0;
        best_g1 = 1'b0;
        p = '0;
        won = 1'b0;
        st_nxt.spi_sec = st_r.spi_sec;
        for (int c = 0; c < NCPU; c++) begin
            best_v = 1'b0;
            best_p = idp_pkg::PRIO_IDLE;
            best_id = idp_pkg::SPURIOUS_ID;
            best_src = '0;
            best_g1 = 1'b0;
            for (int i = 0; i < 16; i++) begin
                for (int s = 0; s < 8; s++) begin
                    p = sgi_prio[c*W +: W] & prio_lsb_mask;
                    if (st_r.sgi_pend[(c*16+i)*8+s] && !st_r.sgi_act[c*16+i] && (!best_v || p < best_p)) begin
                        best_v = 1'b1;
                        best_p = p;
                        best_id = IW'(i);
                        best_src = 3'(s);
                    end
                end
            end
            for (int i = 0; i < NPPI; i++) begin
                p = ppi_prio[c*W +: W] & prio_lsb_mask;
                if (st_r.ppi_pend[c*NPPI+i] && !st_r.ppi_act[c*NPPI+i] && (!best_v || p < best_p)) begin
                    best_v = 1'b1;
                    best_p = p;
                    best_id = IW'(int'(idp_pkg::PPI_BASE) + i);
                    best_src = '0;
                end
            end
            for (int i = 0; i < NSPI; i++) begin
                p = spi_prio[i*W +: W] & prio_lsb_mask;
                if (st_r.spi_pend[i] && !st_r.spi_act[i] && spi_targets[i*NCPU+c] && (!best_v || p < best_p)) begin
                    best_v = 1'b1;
                    best_p = p;
                    best_id = IW'(int'(idp_pkg::SPI_BASE) + i);
                    best_src = '0;
                    best_g1 = spi_group1[i];
                end
            end
            if (st_r.run_id[c*IW +: IW] >= idp_pkg::SPI_BASE && st_r.run_id[c*IW +: IW] != idp_pkg::SPURIOUS_ID) begin
                st_nxt.run_prio[c*W +: W] = spi_prio[int'(st_r.run_id[c*IW +: IW] - idp_pkg::SPI_BASE)*W +: W];
            end
            won = best_v && dist_enable && cpu_enable[c] && best_p < prio_mask[c*W +: W]
                  && best_p < st_nxt.run_prio[c*W +: W];
            st_nxt.nirq[c] = legacy_bypass[c] ? ~leg_irq[c] : ~(won && !best_g1);
            st_nxt.nfiq[c] = legacy_bypass[c] ? ~leg_fiq[c] : ~(won && best_g1 && SEC_EXT);
            if (ack[c]) begin
                if (won) begin
                    st_nxt.ack_id[c*IW +: IW] = best_id;
                    st_nxt.ack_src[c*3 +: 3] = best_src;
                    st_nxt.run_id[c*IW +: IW] = best_id;
                    st_nxt.run_prio[c*W +: W] = best_p;
                    if (best_id < idp_pkg::PPI_BASE) begin
                        st_nxt.sgi_pend[(c*16+int'(best_id))*8+int'(best_src)] = 1'b0;
                        st_nxt.sgi_act[c*16+int'(best_id)] = 1'b1;
                    end else if (best_id < idp_pkg::SPI_BASE) begin
                        st_nxt.ppi_pend[c*NPPI+int'(best_id-idp_pkg::PPI_BASE)] = 1'b0;
                        st_nxt.ppi_act[c*NPPI+int'(best_id-idp_pkg::PPI_BASE)] = 1'b1;
                    end else begin
                        st_nxt.spi_pend[int'(best_id-idp_pkg::SPI_BASE)] = 1'b0;
                        st_nxt.spi_act[int'(best_id-idp_pkg::SPI_BASE)] = 1'b1;
                    end
                end else begin
                    st_nxt.ack_id[c*IW +: IW] = idp_pkg::SPURIOUS_ID;
                    st_nxt.ack_src[c*3 +: 3] = '0;
                end
            end
            if (eoi[c] && st_r.run_id[c*IW +: IW] != idp_pkg::SPURIOUS_ID) begin
                if (st_r.run_id[c*IW +: IW] < idp_pkg::PPI_BASE) begin
                    st_nxt.sgi_act[c*16+int'(st_r.run_id[c*IW +: IW])] = 1'b0;
                end else if (st_r.run_id[c*IW +: IW] < idp_pkg::SPI_BASE) begin
                    st_nxt.ppi_act[c*NPPI+int'(st_r.run_id[c*IW +: IW]-idp_pkg::PPI_BASE)] = 1'b0;
                end else begin
                    st_nxt.spi_act[int'(st_r.run_id[c*IW +: IW]-idp_pkg::SPI_BASE)] = 1'b0;
                end
                st_nxt.run_id[c*IW +: IW] = idp_pkg::SPURIOUS_ID;
                st_nxt.run_prio[c*W +: W] = idp_pkg::PRIO_IDLE;
            end
        end
        // Latch input events after acknowledge so a new event wins over the clear
        for (int i = 0; i < NSPI; i++) begin
            if (spi_pulse_mode[i] ? spi_edge[i] : spi_lvl[i]) begin
                st_nxt.spi_pend[i] = 1'b1;
            end
        end
        for (int i = 0; i < NCPU*NPPI; i++) begin
            if (PPI_PULSE[i % NPPI] ? ppi_edge[i] : ppi_lvl[i]) begin
                st_nxt.ppi_pend[i] = 1'b1;
            end
        end
        if (sgi_req) begin
            for (int c = 0; c < NCPU; c++) begin
                if (sgi_targets[c]) begin
                    st_nxt.sgi_pend[(c*16 + int'(sgi_id))*8 + int'(sgi_source)] = 1'b1;
                end
            end
        end
        for (int c = 0; c < NCPU; c++) begin
            for (int k = 0; k < c; k++) begin
                if (ack[c] && ack[k] && st_nxt.ack_id[c*IW +: IW] == st_nxt.ack_id[k*IW +: IW]
                    && st_nxt.ack_id[c*IW +: IW] >= idp_pkg::SPI_BASE
                    && st_nxt.ack_id[c*IW +: IW] != idp_pkg::SPURIOUS_ID) begin
                    st_nxt.ack_id[c*IW +: IW] = idp_pkg::SPURIOUS_ID;
                    st_nxt.run_id[c*IW +: IW] = st_r.run_id[c*IW +: IW];
                    st_nxt.run_prio[c*W +: W] = st_r.run_prio[c*W +: W];
                end
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.run_id <= {NCPU{idp_pkg::SPURIOUS_ID}};
            st_r.run_prio <= {NCPU{idp_pkg::PRIO_IDLE}};
            st_r.ack_id <= {NCPU{idp_pkg::SPURIOUS_ID}};
            st_r.nirq <= '1;
            st_r.nfiq <= '1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end
    assign ack_id = st_r.ack_id;
    assign ack_src = st_r.ack_src;
    assign nirq = st_r.nirq;
    assign nfiq = st_r.nfiq;
    assign spi_active = st_r.spi_act;
    assign spi_security = st_r.spi_sec;
endmodule : idp_distributor

/* File: testbench/idp_dist_checker.sv */
/*
 Port assertions for the interrupt distributor.
 Assumes one clock and active-low rstn; bound to every idp_distributor.
*/
`timescale 1ns/1ps
module idp_dist_checker #(
    parameter int NCPU = 2,
    parameter int NSPI = 32,
    parameter int NLOCK = 0,
    parameter int PRIO_BITS = 4,
    parameter int ID_TAG_W = 4
) (
    // Clock, reset and legacy bypass
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [NCPU-1:0] legacy_bypass,
    // Bank selection and build-time values
    input wire logic [ID_TAG_W-1:0] bus_id,
    input wire logic bus_secure,
    input wire logic [NCPU*ID_TAG_W-1:0] id_mask,
    input wire logic [NCPU*ID_TAG_W-1:0] id_match,
    input wire logic [NCPU-1:0] bank_sel,
    input wire logic [NCPU-1:0] bank_ns_ok,
    input wire logic [3:0] min_bin_point,
    input wire logic [4:0] lockable_count,
    // Handshake and status
    input wire logic [NCPU-1:0] ack,
    input wire logic [NCPU-1:0] nirq,
    input wire logic [NCPU*idp_pkg::ID_W-1:0] ack_id,
    input wire logic [NSPI-1:0] spi_active,
    input wire logic [NSPI-1:0] spi_security
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // Acknowledge of a signalled interrupt with no rival acknowledge in the cycle before
    sequence s_taken;
        clk_en && !legacy_bypass[0] && ack[0] && !nirq[0] && !$past(ack[1]);
    endsequence
    sequence s_both_acked;
        $past(ack[0] && ack[1]) && ack_id[9:0] >= idp_pkg::SPI_BASE && ack_id[9:0] != idp_pkg::SPURIOUS_ID;
    endsequence
    AST_BANK_SEL: assert property (bank_sel[0] == ((bus_id & id_mask[3:0]) == id_match[3:0]))
        else $error("bank select of interface 0 wrong");
    AST_BANK_NS: assert property (bank_ns_ok == (bank_sel & {NCPU{!bus_secure}}))
        else $error("non-secure bank access wrong");
    AST_BIN_POINT: assert property (min_bin_point == 4'(idp_pkg::PRIO_W - PRIO_BITS - 1))
        else $error("least binary point wrong");
    AST_LOCKABLE: assert property (lockable_count == 5'(NLOCK))
        else $error("lockable count wrong");
    AST_SEC_ZERO: assert property (spi_security == '0)
        else $error("security bits not zero");
    AST_ACK_HOLD: assert property (!$past(ack[0]) |-> $stable(ack_id[9:0]))
        else $error("ack id changed without acknowledge");
    AST_ACCEPT: assert property (s_taken |=> ack_id[9:0] != idp_pkg::SPURIOUS_ID)
        else $error("signalled interrupt answered spurious");
    AST_ACTIVE_CAUSE: assert property ($rose(spi_active[0]) |-> $past(|ack))
        else $error("shared interrupt active without acknowledge");
    AST_ONE_WINNER: assert property (s_both_acked |-> ack_id[19:10] != ack_id[9:0])
        else $error("shared id given to two interfaces");
endmodule : idp_dist_checker

bind idp_distributor idp_dist_checker #(.NCPU(NCPU), .NSPI(NSPI), .NLOCK(NLOCK), .PRIO_BITS(PRIO_BITS),
    .ID_TAG_W(ID_TAG_W)) chk_u (.clock, .rstn, .clk_en, .legacy_bypass, .bus_id, .bus_secure, .id_mask,
    .id_match, .bank_sel, .bank_ns_ok, .min_bin_point, .lockable_count, .ack, .nirq, .ack_id, .spi_active,
    .spi_security);

/* File: testbench/idp_core_model.sv */
/*
 Processor cores: turn bench requests into one-cycle ack and eoi pulses.
 Assumes requests last one cycle; a slow core is a late request.
*/
`timescale 1ns/1ps
module idp_core_model #(
    parameter int NCPU = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Requests
    input wire logic [NCPU-1:0] take,
    input wire logic [NCPU-1:0] retire,
    // To distributor
    output logic [NCPU-1:0] ack,
    output logic [NCPU-1:0] eoi
);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack <= '0;
            eoi <= '0;
        end else begin
            ack <= take;
            eoi <= retire;
        end
    end
endmodule : idp_core_model

/* File: testbench/idp_distributor_tb.sv */
/*
 Self-checking bench for the interrupt distributor.
 Assumes the core model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module idp_distributor_tb;
    typedef struct packed {
        logic [3:0] lines;
        logic [31:0] prio;
        logic [7:0] mask;
        logic [3:0] pulse;
        logic [3:0] grp;
        logic [1:0] irqs;
        logic [9:0] exp;
    } idp_row_s;
    localparam idp_row_s ROWS [6] = '{'{4'h1, 32'h0, 8'hF0, 4'h0, 4'h0, 2'b01, 10'h020},
        '{4'h6, 32'h00202000, 8'hF0, 4'h0, 4'h0, 2'b01, 10'h021},
        '{4'hC, 32'h10400000, 8'hF0, 4'h0, 4'h0, 2'b01, 10'h023},
        '{4'h1, 32'h0, 8'h00, 4'h0, 4'h0, 2'b11, 10'h3FF},
        '{4'h8, 32'h0, 8'hF0, 4'h8, 4'h0, 2'b01, 10'h023},
        '{4'h4, 32'h0, 8'hF0, 4'h0, 4'h4, 2'b10, 10'h022}};
    logic clock, rstn = 1'b0, sgi_req = 1'b0, bus_secure = 1'b0, dist_enable = 1'b1, clk_en = 1'b1;
    logic [1:0] lfiq_n = 2'b11, legacy_bypass = 2'b00;
    logic [3:0] ppi_in = '0, spi_in = '0, spi_pulse_mode = '0, spi_group1 = '0, sgi_id = '0, bus_id = '0;
    logic [7:0] spi_targets = 8'h55, id_mask = 8'h33, id_match = 8'h21;
    logic [31:0] spi_prio = '0;
    logic [15:0] prio_mask = 16'hF0F0, ppi_prio = '0, sgi_prio = '0;
    logic [1:0] legacy_n = 2'b11, cpu_enable = 2'b11, sgi_targets = '0, take = '0, retire = '0, bexp;
    logic [1:0] ack, eoi, nirq, nfiq, bank_sel, bank_ns_ok;
    logic [2:0] sgi_source = '0;
    logic [19:0] ack_id;
    logic [5:0] ack_src;
    logic [3:0] min_bin_point, spi_active, spi_security;
    logic [4:0] lockable_count;
    int failures = 0, num_checks = 0;

    idp_distributor #(.NCPU(2), .NPPI(2), .NSPI(4), .NLOCK(2), .PRIO_BITS(4), .PPI_PULSE(16'h0002)) dut_u (.clock,
        .rstn, .clk_en, .ppi_in, .spi_in, .legacy_irq_n(legacy_n), .legacy_fiq_n(lfiq_n), .sgi_req,
        .sgi_id, .sgi_targets, .sgi_source, .dist_enable, .spi_pulse_mode, .spi_targets, .spi_prio,
        .spi_group1, .ppi_prio, .sgi_prio, .prio_mask, .cpu_enable, .legacy_bypass, .bus_id,
        .bus_secure, .id_mask, .id_match, .bin_point_req(4'h0), .bank_sel, .bank_ns_ok, .min_bin_point,
        .lockable_count, .ack, .eoi, .ack_id, .ack_src, .nirq, .nfiq, .spi_active, .spi_security);
    idp_core_model #(.NCPU(2)) core_u (.clock, .rstn, .take, .retire, .ack, .eoi);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic do_ack(input logic [1:0] m);
        take = m;
        tick();
        take = '0;
        tick();
    endtask : do_ack
    task automatic do_eoi(input int c);
        retire[c] = 1'b1;
        tick();
        retire[c] = 1'b0;
        tick();
    endtask : do_eoi
    task automatic wait_low(input int c);
        for (int n = 0; n < 20 && (nirq[c] & nfiq[c]) === 1'b1; n++) tick();
    endtask : wait_low
    task automatic drain(input int c);
        repeat (4) begin
            repeat (6) tick();
            if ((nirq[c] & nfiq[c]) === 1'b0) begin
                do_ack(2'(1 << c));
                do_eoi(c);
            end
        end
    endtask : drain
    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) tick();
        check("reset ack_id", ack_id, 20'hFFFFF);
        check("reset outputs", {nirq, nfiq, spi_active}, 8'hF0);
        check("reset security", spi_security, 4'h0);
        rstn = 1'b1;
        tick();
    endtask : do_reset
    task automatic report_and_stop();
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        do_reset();
        check("least binary point", min_bin_point, 4'h3);
        check("lockable count", lockable_count, 5'h02);
        do_ack(2'b01);
        check("idle ack_id", ack_id[9:0], 10'h3FF);
        foreach (ROWS[i]) begin
            spi_prio = ROWS[i].prio;
            prio_mask[7:0] = ROWS[i].mask;
            spi_pulse_mode = ROWS[i].pulse;
            spi_group1 = ROWS[i].grp;
            tick();
            spi_in = ROWS[i].lines;
            tick();
            spi_in = spi_in & ~ROWS[i].pulse;
            wait_low(0);
            check("row request lines", {nirq[0], nfiq[0]}, ROWS[i].irqs);
            do_ack(2'b01);
            check("row ack_id", ack_id[9:0], ROWS[i].exp);
            spi_in = '0;
            do_eoi(0);
            prio_mask = 16'hF0F0;
            drain(0);
        end
        spi_targets = 8'h57;
        for (int k = 0; k < 2; k++) begin
            spi_in = 4'h1;
            wait_low(0);
            check("multi nirq", nirq, 2'b00);
            take = k ? 2'b11 : 2'b01;
            tick();
            take = k ? 2'b00 : 2'b10;
            tick();
            take = '0;
            tick();
            check("multi ack_id", ack_id, {10'h3FF, 10'h020});
            check("multi active", spi_active, 4'h1);
            spi_in = '0;
            do_eoi(0);
            drain(0);
            drain(1);
        end
        spi_targets = 8'h55;
        sgi_targets = 2'b01;
        sgi_req = 1'b1;
        sgi_id = 4'h5;
        tick();
        sgi_id = 4'h3;
        sgi_source = 3'h1;
        tick();
        sgi_source = 3'h0;
        tick();
        sgi_req = 1'b0;
        wait_low(0);
        do_ack(2'b01);
        check("sgi id and source", {ack_src[2:0], ack_id[9:0]}, 13'h0003);
        do_eoi(0);
        drain(0);
        ppi_in = 4'h4;
        wait_low(1);
        check("ppi nirq", nirq, 2'b01);
        do_ack(2'b10);
        check("ppi ack_id", ack_id[19:10], 10'h010);
        ppi_in = '0;
        do_eoi(1);
        drain(1);
        ppi_in = 4'h8;
        wait_low(1);
        do_ack(2'b10);
        check("pulse ppi ack_id", ack_id[19:10], 10'h011);
        do_eoi(1);
        repeat (4) tick();
        check("pulse ppi once", nirq[1], 1'b1);
        ppi_in = '0;
        legacy_bypass = 2'b01;
        legacy_n = 2'b10;
        repeat (4) tick();
        check("legacy irq", {nirq, nfiq}, 4'hB);
        legacy_n = 2'b11;
        lfiq_n = 2'b10;
        repeat (4) tick();
        check("legacy fiq", {nirq, nfiq}, 4'hE);
        lfiq_n = 2'b11;
        repeat (4) tick();
        legacy_bypass = 2'b00;
        clk_en = 1'b0;
        dist_enable = 1'b0;
        spi_in = 4'h1;
        repeat (6) tick();
        check("frozen nirq", nirq, 2'b11);
        clk_en = 1'b1;
        repeat (6) tick();
        check("disabled nirq", nirq, 2'b11);
        dist_enable = 1'b1;
        cpu_enable = 2'b10;
        repeat (2) tick();
        check("cpu off nirq", nirq, 2'b11);
        cpu_enable = 2'b11;
        wait_low(0);
        check("enabled nirq", nirq, 2'b10);
        spi_in = '0;
        drain(0);
        for (int b = 0; b < 16; b++) begin
            bus_id = 4'(b);
            bus_secure = b[1];
            tick();
            bexp = {2'(b & 3) == 2'h2, 2'(b & 3) == 2'h1};
            check("bank select", {bank_ns_ok, bank_sel}, {bexp & {2{~b[1]}}, bexp});
        end
        do_reset();
        report_and_stop();
    end
endmodule : idp_distributor_tb
